// *** core/adc_ctrl_defs.vh ***
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// Byte offsets on the register bus
`define OFS_CTRL        8'h00
`define OFS_CLKCFG      8'h04
`define OFS_CHSEL       8'h08
`define OFS_PINCFG      8'h0C
`define OFS_STATUS      8'h10
`define OFS_PORT        8'h14
`define BUF_BASE_HI     2'h1

// Control register fields
`define CTRL_ON_BIT     15
`define CTRL_SIDL_BIT   13
`define CTRL_FMT_LO     8
`define CTRL_START_BIT  1
`define CTRL_DONE_BIT   0

// Clock configuration fields
`define CLK_RC_BIT      7
`define CLK_DIV_W       6

// Status fields
`define STAT_BUSY_BIT   0
`define STAT_PWR_BIT    1
`define STAT_SOFF_BIT   2

// Output format codes
`define FMT_INT         2'h0
`define FMT_SINT        2'h1
`define FMT_FRAC        2'h2
`define FMT_SFRAC       2'h3

// Reset values
`define RST_FMT         2'h0
`define RST_DIV         6'h00
`define RST_CHAN        4'h0
`define RST_PINCFG      16'h0000

// Timing counts
`define TAD_PER_CONV    4'hE
`define TCY_NS          10
`define INSTR_NS        10
`define RC_WAIT_CYC     (((`INSTR_NS) + (`TCY_NS) - 1) / (`TCY_NS))

`endif

// *** core/adc_pin_path.v ***
// Port pin path: synchronises pins, masks analog pins, picks the level to convert
`timescale 1ns/1ps
`default_nettype none

module adc_pin_path (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire [15:0] pin_in,
	input  wire [15:0] pin_out_level,
	input  wire [15:0] pin_direction_bit,
	input  wire [15:0] pin_analog_config,
	input  wire [3:0]  chan,
	input  wire [11:0] afe_data,
	output wire [15:0] port_read,
	output reg  [11:0] sample_val
);

	reg [15:0] pin_meta_ff;
	reg [15:0] pin_sync_ff;

	// Two-stage synchroniser on the pads
	always @(posedge clk) begin
		if (rst) begin
			pin_meta_ff <= 16'h0000;
			pin_sync_ff <= 16'h0000;
		end else if (ce) begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Analog pins read back as zero
	assign port_read = pin_sync_ff & ~pin_analog_config;

	// Value the converter sees on the chosen channel
	always @* begin
		if (!pin_analog_config[chan]) begin
			sample_val = 12'h000;
		end else if (!pin_direction_bit[chan]) begin
			sample_val = {12{pin_out_level[chan]}};
		end else begin
			sample_val = afe_data;
		end
	end

endmodule // adc_pin_path
`default_nettype wire

// *** core/adc_power_sleep_format_ctrl.v ***
// Converter control: power states, Sleep and Idle, reset, result buffer and formats
//
// Summary of operation
// - Module-on set means converter fully powered with sampling and conversion available.
// - Module-on clear turns digital and analog sections off.
// - In Sleep every converter clock except the RC clock stops and is held low.
// - Sleep during a non-RC conversion abandons it; no resume afterwards.
// - Sleep entry or exit leaves every register unchanged.
// - With RC clock, run in Sleep after one instruction-cycle delay.
// - A finished conversion sets the done flag.
// - Completion in Sleep with interrupt enabled raises wake interrupt.
// - Completion in Sleep with interrupt disabled powers off, module-on stays set.
// - In Idle, continue if stop-in-idle is 0, halt if 1.
// - Reset restores registers, turns converter off, aborts any sequence.
// - Reset leaves result buffer untouched; contents undefined after power-on.
// - Results are 12 bits, stored 12 wide, read as formatted 16 bits.
// - Buffer writes are always taken as right-justified integer.
// - Four read layouts: integer, signed integer, fractional, signed fractional.
// - Output-direction pin converts its own driven digital level.
// - Port read returns 0 for analog-configured pins.
// - Digital-input pins are never converted as analog.
// - Clearing module-on mid-conversion aborts; buffer keeps last value.
// - A conversion takes fourteen conversion clock periods.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module adc_power_sleep_format_ctrl (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        cpu_sleep,
	input  wire        cpu_idle,
	input  wire        irq_enable,
	input  wire        rc_clk_in,
	input  wire [11:0] afe_data,
	input  wire [15:0] pin_in,
	input  wire [15:0] pin_out_level,
	input  wire [15:0] pin_direction_bit,
	output wire        analog_power_en,
	output wire        conv_clk_run,
	output wire        sample_hold,
	output wire [3:0]  mux_a_positive_select,
	output wire        wake_irq
);

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_CONV = 2'h2;

	// Software-visible control state
	reg                  module_on_ff;
	reg                  stop_in_idle_ff;
	reg [1:0]            output_format_field_ff;
	reg                  done_ff;
	reg                  internal_rc_clock_select_ff;
	reg [`CLK_DIV_W-1:0] clk_div_ff;
	reg [3:0]            chan_ff;
	reg [15:0]           pin_analog_config_ff;

	// Sequencer state
	reg [1:0]            state_ff;
	reg [1:0]            nxt_state;
	reg [`CLK_DIV_W-1:0] tad_cnt_ff;
	reg [3:0]            step_ff;
	reg [3:0]            wr_ptr_ff;
	reg [11:0]           sample_ff;
	reg                  sleep_off_ff;
	reg                  irq_ff;

	// RC clock synchroniser and edge detect
	reg                  rc_meta_ff;
	reg                  rc_sync_ff;
	reg                  rc_last_ff;

	// Bus slave state
	reg                  ack_ff;
	reg [31:0]           rdata_ff;
	reg [31:0]           nxt_rdata;

	// Result buffer, deliberately without reset
	reg [11:0]           result_buffer [0:15];

	wire [15:0]          port_read;
	wire [11:0]          sample_val;
	wire [15:0]          fmt_val;
	wire [3:0]           buf_idx;
	wire                 buf_hit;
	wire                 wr_acc;
	wire                 ctrl_wr;
	wire                 start_req;
	wire                 clk_stop;
	wire                 idle_halt;
	wire                 rc_tick;
	wire                 tad_tick;
	wire                 abort;
	wire                 last_step;
	wire                 conv_end;

	// Pin masking and sample source
	adc_pin_path u_pins (
		.clk               (clk),
		.rst               (rst),
		.ce                (ce),
		.pin_in            (pin_in),
		.pin_out_level     (pin_out_level),
		.pin_direction_bit (pin_direction_bit),
		.pin_analog_config (pin_analog_config_ff),
		.chan              (chan_ff),
		.afe_data          (afe_data),
		.port_read         (port_read),
		.sample_val        (sample_val)
	);

	// Read formatter for the addressed buffer word
	adc_result_format u_fmt (
		.raw     (result_buffer[buf_idx]),
		.fmt     (output_format_field_ff),
		.bus_val (fmt_val)
	);

	// Bus decode; access completes in the cycle waitrequest is low
	assign buf_hit         = (avs_address[7:6] == `BUF_BASE_HI);
	assign buf_idx         = avs_address[5:2];
	assign wr_acc          = avs_write & ack_ff;
	assign ctrl_wr         = wr_acc & (avs_address == `OFS_CTRL);
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;

	// Clock gating for Sleep and Idle
	assign clk_stop  = cpu_sleep & ~internal_rc_clock_select_ff;
	assign idle_halt = cpu_idle & stop_in_idle_ff;
	assign rc_tick   = rc_sync_ff & ~rc_last_ff;
	assign tad_tick  = internal_rc_clock_select_ff ? (rc_tick & ~idle_halt) :
		((tad_cnt_ff == clk_div_ff) & ~clk_stop & ~idle_halt);

	// Abort on module-off or on Sleep without the RC clock
	assign abort     = ~module_on_ff | clk_stop |
		(ctrl_wr & avs_byteenable[1] & ~avs_writedata[`CTRL_ON_BIT]);
	assign start_req = ctrl_wr & avs_byteenable[0] & avs_writedata[`CTRL_START_BIT] &
		module_on_ff & ~sleep_off_ff & (state_ff == ST_IDLE);
	assign last_step = (step_ff == (`TAD_PER_CONV - 4'h1));
	assign conv_end  = (state_ff == ST_CONV) & ~abort & tad_tick & last_step;

	// Outputs toward the analog front end and the system
	assign analog_power_en       = module_on_ff & ~sleep_off_ff;
	assign conv_clk_run          = analog_power_en & ~clk_stop & ~idle_halt;
	assign sample_hold           = (state_ff == ST_CONV);
	assign mux_a_positive_select = chan_ff;
	assign wake_irq              = irq_ff;

	// RC clock crosses in through two flops before the edge detect
	always @(posedge clk) begin
		if (rst) begin
			rc_meta_ff <= 1'b0;
			rc_sync_ff <= 1'b0;
			rc_last_ff <= 1'b0;
		end else if (ce) begin
			rc_meta_ff <= rc_clk_in;
			rc_sync_ff <= rc_meta_ff;
			rc_last_ff <= rc_sync_ff;
		end
	end

	// Next sequencer state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_req) begin
					nxt_state = internal_rc_clock_select_ff ? ST_WAIT : ST_CONV;
				end
			end
			ST_WAIT: begin
				if (abort) begin
					nxt_state = ST_IDLE;
				end else if (!idle_halt &&
					tad_cnt_ff == (`RC_WAIT_CYC - 1)) begin
					nxt_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (abort || conv_end) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Sequencer, divider and step counting
	always @(posedge clk) begin
		if (rst) begin
			state_ff   <= ST_IDLE;
			tad_cnt_ff <= {`CLK_DIV_W{1'b0}};
			step_ff    <= 4'h0;
			sample_ff  <= 12'h000;
		end else if (ce) begin
			state_ff <= nxt_state;
			if (state_ff != nxt_state || (state_ff == ST_CONV && tad_tick)) begin
				tad_cnt_ff <= {`CLK_DIV_W{1'b0}};
			end else if (!clk_stop && !idle_halt) begin
				tad_cnt_ff <= tad_cnt_ff + {{(`CLK_DIV_W-1){1'b0}}, 1'b1};
			end
			if (nxt_state == ST_CONV && state_ff != ST_CONV) begin
				step_ff   <= 4'h0;
				sample_ff <= sample_val;
			end else if (state_ff == ST_CONV && tad_tick) begin
				step_ff <= step_ff + 4'h1;
			end
		end
	end

	// Power-off after a silent Sleep conversion and the wake pulse
	always @(posedge clk) begin
		if (rst) begin
			sleep_off_ff <= 1'b0;
			irq_ff       <= 1'b0;
		end else if (ce) begin
			irq_ff <= conv_end & cpu_sleep & irq_enable;
			if (conv_end && cpu_sleep && !irq_enable) begin
				sleep_off_ff <= 1'b1;
			end else if (!cpu_sleep) begin
				sleep_off_ff <= 1'b0;
			end
		end
	end

	// Software registers; Sleep has no path into them
	always @(posedge clk) begin
		if (rst) begin
			module_on_ff                <= 1'b0;
			stop_in_idle_ff             <= 1'b0;
			output_format_field_ff      <= `RST_FMT;
			done_ff                     <= 1'b0;
			internal_rc_clock_select_ff <= 1'b0;
			clk_div_ff                  <= `RST_DIV;
			chan_ff                     <= `RST_CHAN;
			pin_analog_config_ff        <= `RST_PINCFG;
		end else if (ce) begin
			if (ctrl_wr && avs_byteenable[1]) begin
				module_on_ff           <= avs_writedata[`CTRL_ON_BIT];
				stop_in_idle_ff        <= avs_writedata[`CTRL_SIDL_BIT];
				output_format_field_ff <= avs_writedata[`CTRL_FMT_LO+1:`CTRL_FMT_LO];
			end
			// Completion sets done and wins over a clearing write
			if (conv_end) begin
				done_ff <= 1'b1;
			end else if (ctrl_wr && avs_byteenable[0]) begin
				done_ff <= avs_writedata[`CTRL_DONE_BIT];
			end
			if (wr_acc && avs_address == `OFS_CLKCFG && avs_byteenable[0]) begin
				internal_rc_clock_select_ff <= avs_writedata[`CLK_RC_BIT];
				clk_div_ff                  <= avs_writedata[`CLK_DIV_W-1:0];
			end
			if (wr_acc && avs_address == `OFS_CHSEL && avs_byteenable[0]) begin
				chan_ff <= avs_writedata[3:0];
			end
			if (wr_acc && avs_address == `OFS_PINCFG) begin
				if (avs_byteenable[0]) begin
					pin_analog_config_ff[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					pin_analog_config_ff[15:8] <= avs_writedata[15:8];
				end
			end
		end
	end

	// Write pointer of the result buffer
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_ff <= 4'h0;
		end else if (ce && conv_end) begin
			wr_ptr_ff <= wr_ptr_ff + 4'h1;
		end
	end

	// Result buffer: conversion first, else software, no reset
	always @(posedge clk) begin
		if (ce) begin
			if (conv_end) begin
				result_buffer[wr_ptr_ff] <= sample_ff;
			end else if (wr_acc && buf_hit) begin
				if (avs_byteenable[0]) begin
					result_buffer[buf_idx][7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					result_buffer[buf_idx][11:8] <= avs_writedata[11:8];
				end
			end
		end
	end

	// Read data selection
	always @* begin
		nxt_rdata = 32'h00000000;
		if (buf_hit) begin
			nxt_rdata = {16'h0000, fmt_val};
		end else begin
			case (avs_address)
				`OFS_CTRL: begin
					nxt_rdata[`CTRL_ON_BIT]                       = module_on_ff;
					nxt_rdata[`CTRL_SIDL_BIT]                     = stop_in_idle_ff;
					nxt_rdata[`CTRL_FMT_LO+1:`CTRL_FMT_LO]        = output_format_field_ff;
					nxt_rdata[`CTRL_DONE_BIT]                     = done_ff;
				end
				`OFS_CLKCFG: begin
					nxt_rdata[`CLK_RC_BIT]     = internal_rc_clock_select_ff;
					nxt_rdata[`CLK_DIV_W-1:0]  = clk_div_ff;
				end
				`OFS_CHSEL:  nxt_rdata[3:0]  = chan_ff;
				`OFS_PINCFG: nxt_rdata[15:0] = pin_analog_config_ff;
				`OFS_STATUS: begin
					nxt_rdata[`STAT_BUSY_BIT] = (state_ff != ST_IDLE);
					nxt_rdata[`STAT_PWR_BIT]  = analog_power_en;
					nxt_rdata[`STAT_SOFF_BIT] = sleep_off_ff;
					nxt_rdata[7:4]            = wr_ptr_ff;
				end
				`OFS_PORT:   nxt_rdata[15:0] = port_read;
				default:     nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// Bus acknowledge one cycle after the request appears
	always @(posedge clk) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else if (ce) begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			if (avs_read && !ack_ff) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

endmodule // adc_power_sleep_format_ctrl
`default_nettype wire

// *** core/adc_result_format.v ***
// Formats a 12-bit stored result into one of four 16-bit bus layouts
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module adc_result_format (
	input  wire [11:0] raw,
	input  wire [1:0]  fmt,
	output reg  [15:0] bus_val
);

	// Layout select
	always @* begin
		case (fmt)
			`FMT_INT:   bus_val = {4'h0, raw};
			`FMT_SINT:  bus_val = {{4{raw[11]}}, raw};
			`FMT_FRAC:  bus_val = {raw, 4'h0};
			`FMT_SFRAC: bus_val = {raw, 4'h0};
			default:    bus_val = {4'h0, raw};
		endcase
	end

endmodule // adc_result_format
`default_nettype wire

// *** verification/adc_ctrl_monitor.sv ***
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        cpu_sleep,
	input wire logic        irq_enable,
	input wire logic        analog_power_en,
	input wire logic        conv_clk_run,
	input wire logic        sample_hold,
	input wire logic [3:0]  mux_a_positive_select,
	input wire logic        wake_irq
);
	// One clock domain, reset masks every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Outputs cleared as reset lets go
	property p_rst_off;
		$fell(rst) |-> !analog_power_en && !sample_hold && !wake_irq
			&& mux_a_positive_select == 4'h0;
	endproperty
	a_rst_off: assert property (p_rst_off)
		else $error("outputs not cleared by reset");

	// No conversion clock without power
	property p_off_clk;
		!analog_power_en |-> !conv_clk_run;
	endproperty
	a_off_clk: assert property (p_off_clk)
		else $error("conversion clock runs while powered off");

	// Converting only while powered
	property p_busy_pwr;
		sample_hold |-> analog_power_en;
	endproperty
	a_busy_pwr: assert property (p_busy_pwr)
		else $error("sampling while powered off");

	// Wake pulse only from Sleep with interrupt enabled
	property p_wake_src;
		wake_irq |-> $past(cpu_sleep) && $past(irq_enable);
	endproperty
	a_wake_src: assert property (p_wake_src)
		else $error("wake pulse without sleep and enable");

	// Wake pulse lasts one cycle
	property p_wake_one;
		wake_irq |=> !wake_irq;
	endproperty
	a_wake_one: assert property (p_wake_one)
		else $error("wake pulse longer than one cycle");

	// Bus answers one cycle after a request
	property p_wait_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_ack: assert property (p_wait_ack)
		else $error("waitrequest not dropped after one cycle");

	// No wait without a request
	property p_wait_idle;
		!avs_read && !avs_write |-> !avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("waitrequest high with no request");

	// Read data hold until the next read is taken
	property p_rd_hold;
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a read");

	// Main scenarios reached
	c_wake: cover property (wake_irq);
	c_end: cover property ($fell(sample_hold) && analog_power_en);
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule // adc_ctrl_monitor

bind adc_power_sleep_format_ctrl adc_ctrl_monitor u_mon (.clk, .rst, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .cpu_sleep, .irq_enable, .analog_power_en,
	.conv_clk_run, .sample_hold, .mux_a_positive_select, .wake_irq);

`default_nettype wire

// *** verification/tb_adc_power_sleep_format_ctrl.sv ***
// Testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module tb_adc_power_sleep_format_ctrl;
	logic        clk = 0, rst = 1, rc = 0;
	logic [7:0]  a = 8'h00;
	logic        rd_r = 0, wr_r = 0, slp = 0, idl = 0, ien = 0;
	logic [31:0] wd = 32'h0, rdata;
	logic [11:0] afe = 12'h000;
	logic [15:0] pin = 16'hFFFF, plev = 16'h0000, pdir = 16'hFFFF, v;
	logic        wreq, pwr, crun, shold, wirq;
	logic [3:0]  mux;
	int          bad_count = 0, samples_checked = 0, cyc = 0, n;

	// Clocks and timeout
	always #5 clk = ~clk;
	always #23 rc = ~rc;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count = bad_count + 1;
			end_sim();
		end
	end

	adc_power_sleep_format_ctrl u_dut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(a),
		.avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .cpu_sleep(slp), .cpu_idle(idl),
		.irq_enable(ien), .rc_clk_in(rc), .afe_data(afe), .pin_in(pin),
		.pin_out_level(plev), .pin_direction_bit(pdir), .analog_power_en(pwr),
		.conv_clk_run(crun), .sample_hold(shold), .mux_a_positive_select(mux),
		.wake_irq(wirq));

	task automatic chk(input [15:0] g, input [15:0] e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input [7:0] ad, input [15:0] d);
		@(posedge clk);
		a <= ad;
		wd <= {16'h0000, d};
		wr_r <= 1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr_r <= 0;
	endtask

	task automatic rd(input [7:0] ad, output [15:0] d);
		@(posedge clk);
		a <= ad;
		rd_r <= 1;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdata[15:0];
		rd_r <= 0;
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Waits while converting, counting cycles
	task automatic busy_wait();
		n = 0;
		@(posedge clk);
		while (shold === 1'b1 && n < 3000) begin
			n = n + 1;
			@(posedge clk);
		end
	endtask

	// Starts one conversion and checks its length and stored value
	task automatic conv(input [15:0] ctl, input [11:0] e);
		logic [15:0] s;
		rd(8'h10, s);
		wr(8'h00, ctl | 16'h0002);
		busy_wait();
		chk(n, 14);
		rd(8'h00, v);
		chk(v[0], 1);
		rd(8'h40 + {2'h0, s[7:4], 2'h0}, v);
		chk(v, {4'h0, e});
	endtask

	task automatic t_reset();
		rd(8'h00, v);
		chk(v, 16'h0000);
		rd(8'h04, v);
		chk(v, 16'h0000);
		rd(8'h30, v);
		chk(v, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_format();
		logic [15:0] e [4] = '{16'h0A5C, 16'hFA5C, 16'hA5C0, 16'hA5C0};
		wr(8'h40, 16'h3A5C);
		for (int f = 0; f < 4; f++) begin
			wr(8'h00, {6'h00, f[1:0], 8'h00});
			rd(8'h40, v);
			chk(v, e[f]);
		end
		$display("test format done");
	endtask

	task automatic t_conv();
		logic [15:0] s;
		wr(8'h0C, 16'h0003);
		wr(8'h00, 16'h8000);
		cycles(8);
		afe <= 12'h123;
		conv(16'h8000, 12'h123);
		wr(8'h08, 16'h0001);
		plev <= 16'h0002;
		pdir <= 16'hFFFD;
		conv(16'h8000, 12'hFFF);
		chk({12'h000, mux}, 16'h0001);
		wr(8'h08, 16'h0002);
		conv(16'h8000, 12'h000);
		// Abort by clearing module-on
		rd(8'h10, s);
		wr(8'h40 + {2'h0, s[7:4], 2'h0}, 16'h0777);
		wr(8'h00, 16'h8002);
		cycles(3);
		wr(8'h00, 16'h0000);
		cycles(2);
		chk(shold, 0);
		chk(pwr, 0);
		rd(8'h00, v);
		chk(v, 16'h0000);
		rd(8'h40 + {2'h0, s[7:4], 2'h0}, v);
		chk(v, 16'h0777);
		$display("test conversion done");
	endtask

	task automatic t_port();
		wr(8'h0C, 16'h00F0);
		rd(8'h14, v);
		chk(v, 16'hFF0F);
		$display("test port done");
	endtask

	task automatic t_sleep();
		wr(8'h0C, 16'h0001);
		wr(8'h08, 16'h0000);
		wr(8'h00, 16'h8000);
		cycles(8);
		wr(8'h00, 16'h8002);
		cycles(3);
		chk(shold, 1);
		slp <= 1;
		cycles(3);
		chk(crun, 0);
		chk(shold, 0);
		rd(8'h00, v);
		chk(v, 16'h8000);
		slp <= 0;
		cycles(30);
		chk(shold, 0);
		// Internal RC clock runs through Sleep
		wr(8'h04, 16'h0080);
		wr(8'h00, 16'h8002);
		slp <= 1;
		ien <= 1;
		n = 0;
		while (wirq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(wirq, 1);
		slp <= 0;
		ien <= 0;
		wr(8'h00, 16'h8002);
		slp <= 1;
		cycles(2);
		busy_wait();
		cycles(2);
		chk(pwr, 0);
		rd(8'h00, v);
		chk(v[15], 1);
		slp <= 0;
		cycles(2);
		chk(pwr, 1);
		$display("test sleep done");
	endtask

	task automatic t_idle();
		wr(8'h04, 16'h0000);
		wr(8'h00, 16'hA002);
		cycles(2);
		idl <= 1;
		cycles(30);
		chk(shold, 1);
		chk(crun, 0);
		idl <= 0;
		busy_wait();
		conv(16'h8000, 12'h123);
		idl <= 1;
		conv(16'h8000, 12'h123);
		idl <= 0;
		$display("test idle done");
	endtask

	// Reset in mid-conversion: registers cleared, buffer kept
	task automatic t_rst_mid();
		logic [15:0] s;
		rd(8'h10, s);
		wr(8'h40 + {2'h0, s[7:4], 2'h0}, 16'h0456);
		wr(8'h00, 16'h8002);
		cycles(3);
		chk(shold, 1);
		rst <= 1;
		cycles(5);
		rst <= 0;
		chk(shold, 0);
		chk(pwr, 0);
		rd(8'h00, v);
		chk(v, 16'h0000);
		rd(8'h40 + {2'h0, s[7:4], 2'h0}, v);
		chk(v, 16'h0456);
		$display("test mid reset done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		t_reset();
		t_format();
		t_conv();
		t_port();
		t_sleep();
		t_idle();
		t_rst_mid();
		end_sim();
	end
endmodule // tb_adc_power_sleep_format_ctrl

`default_nettype wire
